// ==== ehp_host_port.sv ====
// Host-facing command/status and data byte port of the controller
// How it works
// - Command/status port decoded at 68h
// - Data port decoded at 69h
// - Burst-on: burst flag, ack 90h, interrupt
// - Output-full shows in status bit 0
// - Idle burst status reads 10h
// - Pending event shows in status bit 5
// - Consume input byte, dispatch, raise interrupt
// - Read command followed by address byte
// - Read address fetches byte into output
// - Event sets pending flag and interrupt
// - Query returns event header in output
// - Query clears pending flag, status 11h
// - Write: command, address, data, interrupt each
// - Write command code is 81h
// - Burst-off clears status to 00h
`timescale 1ns/100ps
module ehp_host_port
  import ehp_pkg::*;
#(
  parameter int SPACE_ADDR_W = 8
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Host I/O cycle pins
  input  wire logic [15:0] ioAddr,
  input  wire logic        ioRead,
  input  wire logic        ioWrite,
  input  wire logic [7:0]  ioWrData,
  output logic      [7:0]  ioRdData,
  // Interrupt to host
  output logic             controllerInterruptLine,
  // Internal event source
  input  wire logic        eventRequest,
  input  wire logic [7:0]  eventHeader
);

  default clocking cbSys @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Strobe synchronisation and edges
  // ----------------------------------------------------------------
  logic [1:0] strobeLevel;
  logic       rdLevelPrev;
  logic       wrLevelPrev;
  logic       rdRise;
  logic       rdFall;
  logic       wrRise;
  logic       addrIsCmd;
  logic       addrIsData;

  ehp_sync #(
    .WIDTH (2)
  ) u_strobe_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .pinIn    ({ioWrite, ioRead}),
    .levelOut (strobeLevel)
  );

  // Address and write data are held by the host for the whole strobe
  assign rdRise     = strobeLevel[0] & ~rdLevelPrev;
  assign rdFall     = ~strobeLevel[0] & rdLevelPrev;
  assign wrRise     = strobeLevel[1] & ~wrLevelPrev;
  assign addrIsCmd  = (ioAddr == CMD_STATUS_PORT_ADDR);
  assign addrIsData = (ioAddr == BYTE_TRANSFER_PORT_ADDR);

  // ----------------------------------------------------------------
  // Handler state
  // ----------------------------------------------------------------
  ehp_state_t                state;
  ehp_state_t                next_state;
  logic                      inputFull;
  logic                      next_inputFull;
  logic                      inIsCmd;
  logic                      next_inIsCmd;
  logic [7:0]                inByte;
  logic [7:0]                next_inByte;
  logic                      outputFull;
  logic                      next_outputFull;
  logic [7:0]                outByte;
  logic [7:0]                next_outByte;
  logic                      burst;
  logic                      next_burst;
  logic                      eventPending;
  logic                      next_eventPending;
  logic [7:0]                eventByte;
  logic [7:0]                next_eventByte;
  logic [SPACE_ADDR_W-1:0]   memAddr;
  logic [SPACE_ADDR_W-1:0]   next_memAddr;
  logic                      rdSelData;
  logic                      next_rdSelData;
  logic [IRQ_CNT_W-1:0]      irqCount;
  logic [IRQ_CNT_W-1:0]      next_irqCount;
  logic [7:0]                next_ioRdData;
  logic                      take;
  logic                      irqTrig;
  logic                      memWrEn;
  logic [7:0]                memRdData;
  logic [7:0]                statusByte;

  assign statusByte = {2'b00, eventPending, burst, 2'b00, inputFull, outputFull};

  // 256-byte space reached through one address byte
  ehp_space_mem #(
    .ADDR_W (SPACE_ADDR_W)
  ) u_space (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wrEn    (memWrEn),
    .wrAddr  (memAddr),
    .wrData  (inByte),
    .rdAddr  (memAddr),
    .rdData  (memRdData)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_state        = state;
    next_inputFull    = inputFull;
    next_inIsCmd      = inIsCmd;
    next_inByte       = inByte;
    next_outputFull   = outputFull;
    next_outByte      = outByte;
    next_burst        = burst;
    next_eventPending = eventPending;
    next_eventByte    = eventByte;
    next_memAddr      = memAddr;
    next_rdSelData    = rdSelData;
    take              = 1'b0;
    irqTrig           = 1'b0;
    memWrEn           = 1'b0;

    // Host read of data port drains output buffer at end of strobe
    if (rdRise) begin
      next_rdSelData = addrIsData;
    end
    if (rdFall && rdSelData) begin
      next_outputFull = 1'b0;
    end

    unique case (state)
      ST_IDLE: begin
        if (inputFull) begin
          take = 1'b1;
          if (inIsCmd) begin
            case (inByte)
              SPACE_READ_CMD:  next_state = ST_RD_ADDR;
              SPACE_WRITE_CMD: next_state = ST_WR_ADDR;
              FAST_TRANSFER_ON_CMD: begin
                next_burst      = 1'b1;
                next_outByte    = BURST_ACK_BYTE;
                next_outputFull = 1'b1;
              end
              FAST_TRANSFER_OFF_CMD: begin
                next_burst        = 1'b0;
                next_outputFull   = 1'b0;
                next_eventPending = 1'b0;
              end
              EVENT_QUERY_CMD: begin
                next_outByte      = eventPending ? eventByte : NO_EVENT_HEADER;
                next_outputFull   = 1'b1;
                next_eventPending = 1'b0;
              end
              default: ;
            endcase
          end
        end
      end
      ST_RD_ADDR, ST_WR_ADDR: begin
        // A new command abandons the transfer and is dispatched from idle
        if (inputFull && inIsCmd) begin
          next_state = ST_IDLE;
        end else if (inputFull) begin
          take         = 1'b1;
          next_memAddr = inByte[SPACE_ADDR_W-1:0];
          next_state   = (state == ST_RD_ADDR) ? ST_RD_FETCH : ST_WR_DATA;
        end
      end
      ST_RD_FETCH: next_state = ST_RD_LOAD;
      ST_RD_LOAD: begin
        next_outByte    = memRdData;
        next_outputFull = 1'b1;
        irqTrig         = 1'b1;
        next_state      = ST_IDLE;
      end
      ST_WR_DATA: begin
        if (inputFull && inIsCmd) begin
          next_state = ST_IDLE;
        end else if (inputFull) begin
          take       = 1'b1;
          memWrEn    = 1'b1;
          next_state = ST_IDLE;
        end
      end
    endcase

    if (take) begin
      next_inputFull = 1'b0;
      irqTrig        = 1'b1;
    end

    // Host write wins over the consume in the same cycle
    if (wrRise && (addrIsCmd || addrIsData)) begin
      next_inputFull = 1'b1;
      next_inIsCmd   = addrIsCmd;
      next_inByte    = ioWrData;
    end

    // Event arrival wins over query or burst-off clearing
    if (eventRequest) begin
      next_eventPending = 1'b1;
      next_eventByte    = eventHeader;
      irqTrig           = 1'b1;
    end

    // A new trigger restarts the pulse instead of stacking a second one
    next_irqCount = irqTrig ? IRQ_PULSE_LOAD :
                    (irqCount != IRQ_CNT_ZERO) ? irqCount - IRQ_CNT_STEP : irqCount;

    next_ioRdData = addrIsData ? outByte : statusByte;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state                   <= ST_IDLE;
      rdLevelPrev             <= 1'b0;
      wrLevelPrev             <= 1'b0;
      inputFull               <= 1'b0;
      inIsCmd                 <= 1'b0;
      inByte                  <= BYTE_RESET;
      outputFull              <= 1'b0;
      outByte                 <= BYTE_RESET;
      burst                   <= 1'b0;
      eventPending            <= 1'b0;
      eventByte               <= BYTE_RESET;
      memAddr                 <= '0;
      rdSelData               <= 1'b0;
      irqCount                <= IRQ_CNT_ZERO;
      ioRdData                <= STATUS_CLEAR;
      controllerInterruptLine <= 1'b0;
    end else begin
      state                   <= next_state;
      rdLevelPrev             <= strobeLevel[0];
      wrLevelPrev             <= strobeLevel[1];
      inputFull               <= next_inputFull;
      inIsCmd                 <= next_inIsCmd;
      inByte                  <= next_inByte;
      outputFull              <= next_outputFull;
      outByte                 <= next_outByte;
      burst                   <= next_burst;
      eventPending            <= next_eventPending;
      eventByte               <= next_eventByte;
      memAddr                 <= next_memAddr;
      rdSelData               <= next_rdSelData;
      irqCount                <= next_irqCount;
      ioRdData                <= next_ioRdData;
      controllerInterruptLine <= (next_irqCount != IRQ_CNT_ZERO);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic cmdTaken;
  assign cmdTaken = take && inIsCmd && (state == ST_IDLE);

  property p_burst_ack;
    (cmdTaken && inByte == FAST_TRANSFER_ON_CMD) |=>
      (burst && outputFull && outByte == BURST_ACK_BYTE && controllerInterruptLine);
  endproperty
  a_burst_ack: assert property (p_burst_ack) else $error("burst ack not posted");
  property p_consume_irq;
    take |=> controllerInterruptLine [*2];
  endproperty
  a_consume_irq: assert property (p_consume_irq) else $error("no interrupt after consume");
  property p_ibf_clear;
    (take && !wrRise) |=> !inputFull && !statusByte[STAT_IN_FULL_BIT];
  endproperty
  a_ibf_clear: assert property (p_ibf_clear) else $error("input full not cleared");
  property p_write_sets_ibf;
    (wrRise && (addrIsCmd || addrIsData)) |=> inputFull && (inByte == $past(ioWrData));
  endproperty
  a_write_sets_ibf: assert property (p_write_sets_ibf) else $error("host write lost");
  property p_read_fetch;
    (state == ST_RD_ADDR && take) |=> ##2 (outputFull && outByte == $past(memRdData)
      && statusByte[STAT_OUT_FULL_BIT]);
  endproperty
  a_read_fetch: assert property (p_read_fetch) else $error("read data not loaded");
  property p_event_sets;
    eventRequest |=> eventPending && statusByte[STAT_EVENT_BIT] && controllerInterruptLine;
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("event not flagged");
  property p_query_clears;
    (cmdTaken && inByte == EVENT_QUERY_CMD && !eventRequest) |=>
      !eventPending && outputFull;
  endproperty
  a_query_clears: assert property (p_query_clears) else $error("query left event set");
  property p_burst_off;
    (cmdTaken && inByte == FAST_TRANSFER_OFF_CMD && !eventRequest && !wrRise) |=>
      statusByte == STATUS_CLEAR;
  endproperty
  a_burst_off: assert property (p_burst_off) else $error("status not cleared");
  property p_status_read;
    addrIsCmd |=> ioRdData == $past(statusByte);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status port wrong");
  property p_data_drain;
    (rdFall && rdSelData && state != ST_RD_LOAD && !take) |=> !outputFull;
  endproperty
  a_data_drain: assert property (p_data_drain) else $error("output full kept");
  property p_cov_write_xfer;
    memWrEn;
  endproperty
  c_write_xfer: cover property (p_cov_write_xfer);
  property p_cov_read_xfer;
    state == ST_RD_LOAD;
  endproperty
  c_read_xfer: cover property (p_cov_read_xfer);
  property p_cov_query;
    cmdTaken && inByte == EVENT_QUERY_CMD && eventPending;
  endproperty
  c_query: cover property (p_cov_query);
endmodule : ehp_host_port

// ==== ehp_pkg.sv ====
// Constants shared by the host port handshake block
package ehp_pkg;

  // ----------------------------------------------------------------
  // Port decode
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_STATUS_PORT_ADDR = 16'h0068;
  localparam logic [15:0] BYTE_TRANSFER_PORT_ADDR = 16'h0069;

  // ----------------------------------------------------------------
  // Command codes and answers
  // ----------------------------------------------------------------
  localparam logic [7:0] SPACE_READ_CMD = 8'h80;
  localparam logic [7:0] SPACE_WRITE_CMD = 8'h81;
  localparam logic [7:0] FAST_TRANSFER_ON_CMD = 8'h82;
  localparam logic [7:0] FAST_TRANSFER_OFF_CMD = 8'h83;
  localparam logic [7:0] EVENT_QUERY_CMD = 8'h84;
  localparam logic [7:0] BURST_ACK_BYTE = 8'h90;
  localparam logic [7:0] NO_EVENT_HEADER = 8'h00;

  // ----------------------------------------------------------------
  // Status byte layout
  // ----------------------------------------------------------------
  localparam int STAT_OUT_FULL_BIT = 0;
  localparam int STAT_IN_FULL_BIT = 1;
  localparam int STAT_BURST_BIT = 4;
  localparam int STAT_EVENT_BIT = 5;
  localparam logic [7:0] STATUS_CLEAR = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int IRQ_PULSE_NS = 200;
  localparam int IRQ_PULSE_CYCLES =
    (IRQ_PULSE_NS / CLK_PERIOD_NS) < 1 ? 1 : (IRQ_PULSE_NS / CLK_PERIOD_NS);
  localparam int IRQ_CNT_W = 4;
  localparam logic [IRQ_CNT_W-1:0] IRQ_PULSE_LOAD = IRQ_CNT_W'(IRQ_PULSE_CYCLES);
  localparam logic [IRQ_CNT_W-1:0] IRQ_CNT_ZERO = 4'h0;
  localparam logic [IRQ_CNT_W-1:0] IRQ_CNT_STEP = 4'h1;

  // ----------------------------------------------------------------
  // Handler states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_ADDR,
    ST_RD_FETCH,
    ST_RD_LOAD,
    ST_WR_ADDR,
    ST_WR_DATA
  } ehp_state_t;

endpackage : ehp_pkg

// ==== ehp_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module ehp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Asynchronous pins and filtered levels
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] levelOut
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_levelOut;

  // Level moves only when the last two stages agree
  always_comb begin
    next_levelOut = (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & levelOut);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage1   <= '0;
      stage2   <= '0;
      stage3   <= '0;
      levelOut <= '0;
    end else begin
      stage1   <= pinIn;
      stage2   <= stage1;
      stage3   <= stage2;
      levelOut <= next_levelOut;
    end
  end

endmodule : ehp_sync

// ==== ehp_space_mem.sv ====
// Byte-wide internal controller space held in flip-flops
`timescale 1ns/100ps
module ehp_space_mem
  import ehp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Write port
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [7:0]        wrData,
  // Read port, one cycle latency
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [7:0]        rdData
);

  logic [7:0] mem [2**ADDR_W];

  genvar g;
  generate
    for (g = 0; g < 2**ADDR_W; g++) begin : g_entry
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          mem[g] <= BYTE_RESET;
        end else if (wrEn && (wrAddr == ADDR_W'(g))) begin
          mem[g] <= wrData;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= BYTE_RESET;
    end else begin
      rdData <= mem[rdAddr];
    end
  end

endmodule : ehp_space_mem

// ==== ehp_host_model.sv ====
// Host processor model driving the I/O port cycles
`timescale 1ns/100ps
module ehp_host_model
  import ehp_pkg::*;
(
  // Clock
  input  wire logic        clk_sys,
  // Host I/O cycle pins
  output logic      [15:0] ioAddr,
  output logic             ioRead,
  output logic             ioWrite,
  output logic      [7:0]  ioWrData,
  input  wire logic [7:0]  ioRdData,
  input  wire logic        controllerInterruptLine,
  // Observations for the bench
  output logic             rdDone,
  output logic      [7:0]  rdByte,
  output logic      [15:0] irqCount
);
  logic irqLast;

  initial begin
    ioAddr   = 16'h0000;
    ioRead   = 1'b0;
    ioWrite  = 1'b0;
    ioWrData = 8'h00;
    rdDone   = 1'b0;
    rdByte   = 8'h00;
    irqCount = 16'h0000;
    irqLast  = 1'b0;
  end

  // Count interrupt pulses by their rising edge
  always @(posedge clk_sys) begin
    if (controllerInterruptLine === 1'b1 && irqLast !== 1'b1) begin
      irqCount <= irqCount + 16'h0001;
    end
    irqLast <= controllerInterruptLine;
  end

  // Strobe held well past the 3-4 cycle filter, then low long enough to fall
  task automatic busCycle(input logic wr, input logic [15:0] a, input logic [7:0] d,
                          output logic [7:0] got);
    @(posedge clk_sys);
    #2;
    ioAddr   = a;
    ioWrData = wr ? d : ~ioWrData;
    ioWrite  = wr;
    ioRead   = !wr;
    repeat (6) @(posedge clk_sys);
    // Sample once the edge's register updates have landed
    #1;
    got = ioRdData;
    #1;
    ioWrite  = 1'b0;
    ioRead   = 1'b0;
    ioAddr   = ~a;
    ioWrData = ~ioWrData;
    repeat (6) @(posedge clk_sys);
  endtask : busCycle

  task automatic pollStatus(input int bitNo, input logic want);
    logic [7:0] st;
    st = ~{8{want}};
    for (int i = 0; i < 8 && st[bitNo] !== want; i++) begin
      busCycle(1'b0, CMD_STATUS_PORT_ADDR, 8'h00, st);
    end
  endtask : pollStatus

  task automatic hostWrite(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] unused;
    pollStatus(STAT_IN_FULL_BIT, 1'b0);
    busCycle(1'b1, a, d, unused);
    repeat (20) @(posedge clk_sys);
  endtask : hostWrite

  task automatic hostRead(input logic [15:0] a);
    logic [7:0] got;
    if (a == BYTE_TRANSFER_PORT_ADDR) begin
      pollStatus(STAT_OUT_FULL_BIT, 1'b1);
    end
    busCycle(1'b0, a, 8'h00, got);
    #2;
    rdByte = got;
    rdDone = 1'b1;
    @(posedge clk_sys);
    #2;
    rdDone = 1'b0;
  endtask : hostRead
endmodule : ehp_host_model

// ==== tb_top.sv ====
// Self-checking bench for the host port handshake block
`timescale 1ns/100ps
module tb_top;
  import ehp_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] ioAddr;
  logic        ioRead;
  logic        ioWrite;
  logic [7:0]  ioWrData;
  logic [7:0]  ioRdData;
  logic        irqLine;
  logic        eventRequest = 1'b0;
  logic [7:0]  eventHeader = 8'h00;
  logic        rdDone;
  logic [7:0]  rdByte;
  logic [15:0] irqCount;
  logic [15:0] irqExp = 16'h0000;
  logic [7:0]  expQ[$];
  logic [7:0]  memModel[256];
  logic [31:0] seed = 32'h6341b669;
  logic [7:0]  a;
  logic [7:0]  d;
  int          errors = 0;
  int          num_checks = 0;
  int          cycles = 0;

  always #25 clk_sys = ~clk_sys;

  ehp_host_port ehp_host_port_i (.clk_sys(clk_sys), .rst_n(rst_n), .ioAddr(ioAddr),
    .ioRead(ioRead), .ioWrite(ioWrite), .ioWrData(ioWrData), .ioRdData(ioRdData),
    .controllerInterruptLine(irqLine), .eventRequest(eventRequest),
    .eventHeader(eventHeader));
  ehp_host_model ehp_host_model_i (.clk_sys(clk_sys), .ioAddr(ioAddr), .ioRead(ioRead),
    .ioWrite(ioWrite), .ioWrData(ioWrData), .ioRdData(ioRdData),
    .controllerInterruptLine(irqLine), .rdDone(rdDone), .rdByte(rdByte),
    .irqCount(irqCount));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xorshift = x ^ (x << 5);
  endfunction : xorshift

  task automatic nextRand(output logic [7:0] v);
    seed = xorshift(seed);
    v = seed[7:0];
  endtask : nextRand

  task automatic compare(input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (exp !== got) begin
      errors++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : compare

  task automatic compareIrq(input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (exp !== got) begin
      errors++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : compareIrq

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  // Watcher: every reported read takes the oldest expectation
  always @(posedge clk_sys) begin
    if (rdDone === 1'b1) begin
      if (expQ.size() == 0) begin
        compare(16'hFFFF, {8'h00, rdByte});
      end else begin
        compare({8'h00, expQ.pop_front()}, {8'h00, rdByte});
      end
    end
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 20000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic expRd(input logic [15:0] addr, input logic [7:0] e);
    expQ.push_back(e);
    ehp_host_model_i.hostRead(addr);
  endtask : expRd

  // Each accepted byte is answered by exactly one interrupt pulse
  task automatic wr(input logic [15:0] addr, input logic [7:0] v);
    ehp_host_model_i.hostWrite(addr, v);
    irqExp = irqExp + 16'h0001;
    compareIrq(irqExp, irqCount);
  endtask : wr

  task automatic raiseEvent(input logic [7:0] h);
    @(posedge clk_sys);
    #2;
    eventRequest = 1'b1;
    eventHeader  = h;
    @(posedge clk_sys);
    #2;
    eventRequest = 1'b0;
    eventHeader  = ~h;
    irqExp = irqExp + 16'h0001;
    repeat (8) @(posedge clk_sys);
    compareIrq(irqExp, irqCount);
  endtask : raiseEvent

  initial begin
    for (int i = 0; i < 256; i++) memModel[i] = 8'h00;
    repeat (2) @(posedge clk_sys);
    #2;
    rst_n = 1'b1;
    expRd(CMD_STATUS_PORT_ADDR, 8'h00);
    ehp_host_model_i.hostWrite(16'h006A, FAST_TRANSFER_ON_CMD);
    compareIrq(irqExp, irqCount);
    expRd(CMD_STATUS_PORT_ADDR, 8'h00);
    $display("test decode done");
    wr(CMD_STATUS_PORT_ADDR, FAST_TRANSFER_ON_CMD);
    expRd(CMD_STATUS_PORT_ADDR, 8'h11);
    expRd(BYTE_TRANSFER_PORT_ADDR, BURST_ACK_BYTE);
    expRd(CMD_STATUS_PORT_ADDR, 8'h10);
    $display("test burst on done");
    for (int i = 0; i < 6; i++) begin
      nextRand(a);
      nextRand(d);
      if (i == 0) a = 8'hFF;
      if (i == 1) a = 8'h00;
      wr(CMD_STATUS_PORT_ADDR, SPACE_WRITE_CMD);
      wr(BYTE_TRANSFER_PORT_ADDR, a);
      wr(BYTE_TRANSFER_PORT_ADDR, d);
      memModel[a] = d;
    end
    for (int i = 0; i < 8; i++) begin
      nextRand(a);
      if (i == 0) a = 8'hFF;
      if (i == 1) a = 8'h00;
      wr(CMD_STATUS_PORT_ADDR, SPACE_READ_CMD);
      wr(BYTE_TRANSFER_PORT_ADDR, a);
      expRd(CMD_STATUS_PORT_ADDR, 8'h11);
      expRd(BYTE_TRANSFER_PORT_ADDR, memModel[a]);
    end
    $display("test space transfers done");
    // Command while an address is awaited restarts as the new command
    a = 8'hFF;
    wr(CMD_STATUS_PORT_ADDR, SPACE_WRITE_CMD);
    wr(CMD_STATUS_PORT_ADDR, SPACE_READ_CMD);
    wr(BYTE_TRANSFER_PORT_ADDR, a);
    expRd(BYTE_TRANSFER_PORT_ADDR, memModel[a]);
    // Unknown command and a stray data byte are consumed with no other effect
    wr(CMD_STATUS_PORT_ADDR, 8'h85);
    wr(BYTE_TRANSFER_PORT_ADDR, a);
    expRd(CMD_STATUS_PORT_ADDR, 8'h10);
    $display("test abort done");
    nextRand(d);
    raiseEvent(d);
    expRd(CMD_STATUS_PORT_ADDR, 8'h30);
    wr(CMD_STATUS_PORT_ADDR, EVENT_QUERY_CMD);
    expRd(CMD_STATUS_PORT_ADDR, 8'h11);
    expRd(BYTE_TRANSFER_PORT_ADDR, d);
    expRd(CMD_STATUS_PORT_ADDR, 8'h10);
    $display("test query done");
    nextRand(a);
    nextRand(d);
    wr(CMD_STATUS_PORT_ADDR, SPACE_READ_CMD);
    raiseEvent(d);
    expRd(CMD_STATUS_PORT_ADDR, 8'h30);
    wr(BYTE_TRANSFER_PORT_ADDR, a);
    expRd(CMD_STATUS_PORT_ADDR, 8'h31);
    expRd(BYTE_TRANSFER_PORT_ADDR, memModel[a]);
    wr(CMD_STATUS_PORT_ADDR, EVENT_QUERY_CMD);
    expRd(BYTE_TRANSFER_PORT_ADDR, d);
    wr(CMD_STATUS_PORT_ADDR, EVENT_QUERY_CMD);
    expRd(BYTE_TRANSFER_PORT_ADDR, NO_EVENT_HEADER);
    $display("test mid-transfer event done");
    nextRand(d);
    raiseEvent(d);
    wr(CMD_STATUS_PORT_ADDR, FAST_TRANSFER_OFF_CMD);
    expRd(CMD_STATUS_PORT_ADDR, STATUS_CLEAR);
    $display("test burst off done");
    end_of_test();
  end
endmodule : tb_top
